// >>> lipd_pkg.sv
package lipd_pkg;
	// ----------------------------------------
	// Counts and widths
	// ----------------------------------------
	localparam int LIPD_NUM_RX = 5;
	localparam int LIPD_NUM_TX = 3;
	localparam int LIPD_CLK_MHZ = 50;
	localparam int LIPD_IDLE_TIMEOUT_US = 30;
	// A least time, so the count is exact here and would round up otherwise.
	localparam int LIPD_IDLE_CYCLES = LIPD_IDLE_TIMEOUT_US * LIPD_CLK_MHZ;
	localparam int LIPD_CNT_W = 12;
	localparam logic [LIPD_CNT_W-1:0] LIPD_CNT_RST = 12'h000;
	localparam logic [LIPD_NUM_RX-1:0] LIPD_RX_RST = 5'h00;
	// Synchronisers start at the released override levels, so reset is not followed by a sleep.
	localparam logic [LIPD_NUM_RX+2:0] LIPD_SYNC_RST = 8'h40;

	typedef enum logic [1:0] {
		LIPD_PWR_ON = 2'b01,
		LIPD_PWR_OFF = 2'b10
	} lipd_pwr_t;
endpackage : lipd_pkg

// >>> lipd_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------
// Summary of operation
// ----------------------------------------
module lipd_ctrl
	import lipd_pkg::*;
#(
	parameter logic [LIPD_CNT_W-1:0] IDLE_CYCLES = LIPD_CNT_W'(LIPD_IDLE_CYCLES)
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic force_awake_in,
	input wire logic force_sleep_n_in,
	input wire logic rx_drive_on_in,
	input wire logic [LIPD_NUM_RX-1:0] rx_valid_in,
	input wire logic [LIPD_NUM_RX-1:0] rx_data_in,
	input wire logic [LIPD_NUM_TX-1:0] tx_data_in,
	output logic supply_on_out,
	output logic [LIPD_NUM_TX-1:0] tx_data_out,
	output logic [LIPD_NUM_TX-1:0] tx_oe_b_out,
	output logic [LIPD_NUM_RX-1:0] rx_inv_out,
	output logic [LIPD_NUM_RX-1:0] rx_oe_b_out,
	output logic always_on_monitor_output_out,
	output logic line_valid_out,
	output logic activity_latch_out
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [LIPD_NUM_RX+2:0] meta_q;
	logic [LIPD_NUM_RX+2:0] sync_q;
	logic [LIPD_NUM_RX-1:0] data_meta_q;
	logic [LIPD_NUM_RX-1:0] data_sync_q;
	logic [LIPD_NUM_RX-1:0] data_prev_q;
	logic awake_s;
	logic sleep_n_s;
	logic en_s;
	logic en_prev_q;
	logic any_valid_s;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_q <= LIPD_SYNC_RST;
			sync_q <= LIPD_SYNC_RST;
			data_meta_q <= LIPD_RX_RST;
			data_sync_q <= LIPD_RX_RST;
		end else begin
			meta_q <= {force_awake_in, force_sleep_n_in, rx_drive_on_in, rx_valid_in};
			sync_q <= meta_q;
			data_meta_q <= rx_data_in;
			data_sync_q <= data_meta_q;
		end
	end

	assign awake_s = sync_q[LIPD_NUM_RX+2];
	assign sleep_n_s = sync_q[LIPD_NUM_RX+1];
	assign en_s = sync_q[LIPD_NUM_RX];
	assign any_valid_s = |sync_q[LIPD_NUM_RX-1:0];

	// ----------------------------------------
	// Idle timer and power state
	// ----------------------------------------
	// Counting the whole window stops a slowly slewing input from tripping shutdown.
	logic [LIPD_CNT_W-1:0] idle_cnt_q;
	logic idle_done;
	lipd_pwr_t auto_q;
	logic pwr_on;

	assign idle_done = (idle_cnt_q >= IDLE_CYCLES);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idle_cnt_q <= LIPD_CNT_RST;
		end else if (any_valid_s) begin
			idle_cnt_q <= LIPD_CNT_RST;
		end else if (!idle_done) begin
			idle_cnt_q <= idle_cnt_q + LIPD_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			auto_q <= LIPD_PWR_ON;
		end else begin
			unique case (auto_q)
				LIPD_PWR_ON: begin
					if (idle_done && !any_valid_s) auto_q <= LIPD_PWR_OFF;
				end
				LIPD_PWR_OFF: begin
					if (any_valid_s) auto_q <= LIPD_PWR_ON;
				end
				default: auto_q <= LIPD_PWR_ON;
			endcase
		end
	end

	// Overrides take priority; force_sleep_n beats force_awake.
	assign pwr_on = !sleep_n_s ? 1'b0 :
		awake_s ? 1'b1 :
		(auto_q == LIPD_PWR_ON);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			supply_on_out <= 1'b1;
			tx_data_out <= '0;
			tx_oe_b_out <= '1;
		end else begin
			supply_on_out <= pwr_on;
			tx_data_out <= tx_data_in;
			tx_oe_b_out <= {LIPD_NUM_TX{!pwr_on}};
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_inv_out <= '1;
			rx_oe_b_out <= '1;
			always_on_monitor_output_out <= 1'b0;
			line_valid_out <= 1'b0;
		end else begin
			rx_inv_out <= ~data_sync_q;
			rx_oe_b_out <= {LIPD_NUM_RX{!en_s}};
			always_on_monitor_output_out <= data_sync_q[LIPD_NUM_RX-1];
			line_valid_out <= any_valid_s;
		end
	end

	// ----------------------------------------
	// Activity detector
	// ----------------------------------------
	logic any_edge;
	assign any_edge = |(data_sync_q ^ data_prev_q);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			data_prev_q <= LIPD_RX_RST;
			en_prev_q <= 1'b0;
			activity_latch_out <= 1'b0;
		end else begin
			data_prev_q <= data_sync_q;
			en_prev_q <= en_s;
			// Set wins over a clear in the same cycle so no edge is lost.
			if (any_edge) activity_latch_out <= 1'b1;
			else if (en_prev_q && !en_s) activity_latch_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_idle_run;
		!any_valid_s && sleep_n_s && !awake_s;
	endsequence

	property p_forced_off;
		@(posedge clk_in) disable iff (!rst_b_in) !sleep_n_s |=> !supply_on_out && &tx_oe_b_out;
	endproperty
	a_forced_off: assert property (p_forced_off) else $error("forced sleep not honoured");

	property p_forced_on;
		@(posedge clk_in) disable iff (!rst_b_in) sleep_n_s && awake_s |=> supply_on_out;
	endproperty
	a_forced_on: assert property (p_forced_on) else $error("forced awake not honoured");

	property p_no_early_off;
		@(posedge clk_in) disable iff (!rst_b_in)
			any_valid_s ##1 (s_idle_run [*8]) |=> supply_on_out;
	endproperty
	a_no_early_off: assert property (p_no_early_off) else $error("early shutdown");

	property p_wake;
		@(posedge clk_in) disable iff (!rst_b_in)
			any_valid_s && sleep_n_s ##1 sleep_n_s |=> supply_on_out;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on valid level");

	property p_timeout;
		@(posedge clk_in) disable iff (!rst_b_in)
			(idle_done and s_idle_run) ##1 s_idle_run |=> !supply_on_out && &tx_oe_b_out;
	endproperty
	a_timeout: assert property (p_timeout) else $error("no shutdown after timeout");

	property p_valid;
		@(posedge clk_in) disable iff (!rst_b_in) line_valid_out == $past(any_valid_s);
	endproperty
	a_valid: assert property (p_valid) else $error("line valid wrong");

	property p_set;
		@(posedge clk_in) disable iff (!rst_b_in) any_edge |=> activity_latch_out;
	endproperty
	a_set: assert property (p_set) else $error("activity not latched");

	property p_hold_high;
		@(posedge clk_in) disable iff (!rst_b_in)
			activity_latch_out && !$fell(en_s) |=> activity_latch_out;
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("latch dropped without clear");

	property p_clear;
		@(posedge clk_in) disable iff (!rst_b_in)
			$fell(en_s) && !any_edge ##1 !any_edge |-> !activity_latch_out;
	endproperty
	a_clear: assert property (p_clear) else $error("activity not cleared");

	property p_hold_low;
		@(posedge clk_in) disable iff (!rst_b_in)
			!activity_latch_out && !any_edge |=> !activity_latch_out;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("latch rose without edge");

	property p_rx_en;
		@(posedge clk_in) disable iff (!rst_b_in) !en_s |=> &rx_oe_b_out;
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("receivers not tristated");
endmodule : lipd_ctrl

// >>> lipd_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the power controls
// ----------------------------------------
module lipd_host (
	input wire logic clk_in,
	output logic force_awake_out,
	output logic force_sleep_n_out,
	output logic rx_drive_on_out
);
	// Held awake at startup so a remote partner has time to wake.
	initial begin
		force_awake_out = 1'b1;
		force_sleep_n_out = 1'b1;
		rx_drive_on_out = 1'b1;
		repeat (30) @(negedge clk_in);
		force_awake_out = 1'b0;
	end
	task automatic set_mode(input logic awake, input logic sleep_n, input logic en);
		@(negedge clk_in);
		force_awake_out = awake;
		force_sleep_n_out = sleep_n;
		rx_drive_on_out = en;
	endtask : set_mode
	// Three cycles high so the pulse survives the input synchroniser.
	task automatic clear_latch();
		@(negedge clk_in);
		rx_drive_on_out = 1'b1;
		repeat (3) @(negedge clk_in);
		rx_drive_on_out = 1'b0;
	endtask : clear_latch
endmodule : lipd_host

// >>> line_idle_power_down_ctrl_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module line_idle_power_down_ctrl_bench;
	import lipd_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic fa, fs_n, en, sup, lv, lat, mon;
	logic [4:0] rx_valid_in, rx_data_in, rx_inv, rx_oe_b;
	logic [2:0] tx_data_in, tx_d, tx_oe_b;
	int n_fail = 0;
	int checks_done = 0;
	wire logic [7:0] st = {2'h0, sup, tx_oe_b, lv, lat};
	initial forever #10 clk_in = ~clk_in;
	lipd_host host_u (.clk_in(clk_in), .force_awake_out(fa), .force_sleep_n_out(fs_n),
		.rx_drive_on_out(en));
	lipd_ctrl #(.IDLE_CYCLES(12'h014)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.force_awake_in(fa), .force_sleep_n_in(fs_n), .rx_drive_on_in(en),
		.rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .tx_data_in(tx_data_in),
		.supply_on_out(sup), .tx_data_out(tx_d), .tx_oe_b_out(tx_oe_b), .rx_inv_out(rx_inv),
		.rx_oe_b_out(rx_oe_b), .always_on_monitor_output_out(mon), .line_valid_out(lv),
		.activity_latch_out(lat));
	// Supply state, driver enables, line status and latch in one word.
	function automatic logic [7:0] exp_st(input logic on, input logic v, input logic a);
		return {2'h0, on, {3{~on}}, v, a};
	endfunction : exp_st
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#20000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		rx_valid_in = 5'h00;
		rx_data_in = 5'h00;
		tx_data_in = 3'h0;
		void'($urandom(32'h2df0));
		cyc(4);
		rst_b_in = 1'b1;
		cyc(1);
		chk(st, exp_st(1'b1, 1'b0, 1'b0));
		for (int i = 0; i < 20; i++) begin
			@(negedge clk_in);
			rx_valid_in = 5'($urandom_range(1, 31));
			rx_data_in ^= 5'($urandom_range(1, 31));
			tx_data_in = 3'($urandom);
			cyc(4);
			chk(st, exp_st(1'b1, 1'b1, 1'b1));
			chk(8'({rx_inv, tx_d}), 8'({~rx_data_in, tx_data_in}));
			chk(8'(mon), 8'(rx_data_in[4]));
			chk(8'(rx_oe_b), 8'h00);
		end
		host_u.clear_latch();
		cyc(6);
		chk(st, exp_st(1'b1, 1'b1, 1'b0));
		cyc(10);
		chk(st, exp_st(1'b1, 1'b1, 1'b0));
		rx_data_in[0] = ~rx_data_in[0];
		cyc(5);
		chk(st, exp_st(1'b1, 1'b1, 1'b1));
		// A short valid pulse mid-count must restart the idle timer.
		host_u.set_mode(1'b0, 1'b1, 1'b1);
		rx_valid_in = 5'h00;
		cyc(10);
		rx_valid_in = 5'h02;
		cyc(2);
		rx_valid_in = 5'h00;
		cyc(18);
		chk(st, exp_st(1'b1, 1'b0, 1'b1));
		cyc(12);
		chk(st, exp_st(1'b0, 1'b0, 1'b1));
		host_u.set_mode(1'b0, 1'b1, 1'b0);
		rx_data_in[4] = ~rx_data_in[4];
		cyc(4);
		chk(8'({rx_oe_b, mon, tx_oe_b[0]}), 8'({5'h1f, rx_data_in[4], 1'b1}));
		rx_valid_in = 5'h04;
		cyc(5);
		chk(st, exp_st(1'b1, 1'b1, 1'b1));
		host_u.set_mode(1'b1, 1'b1, 1'b1);
		rx_valid_in = 5'h00;
		cyc(40);
		chk(st, exp_st(1'b1, 1'b0, 1'b1));
		host_u.set_mode(1'b1, 1'b0, 1'b1);
		rx_valid_in = 5'h1f;
		cyc(4);
		chk(st, exp_st(1'b0, 1'b1, 1'b1));
		report_and_stop();
	end
endmodule : line_idle_power_down_ctrl_bench
